// *** core/dade_exec.sv ***
// four-phase execution datapath for decimal adjust and file-register decrement
// assumes instruction word, memory read data and loads come from logic on clk;
// data memory answers a read in the same cycle as mem_re
`timescale 1ns/1ps
`default_nettype none

module dade_exec (
    input  wire logic                  clk,
    input  wire logic                  rstn,
    input  wire logic                  instr_valid,
    input  wire logic [15:0]           instr,
    input  wire logic                  ext_set_en,
    input  wire logic [11:0]           index_base,
    input  wire logic [3:0]            bank_pointer_reg,
    input  wire logic                  acc_load,
    input  wire logic [7:0]            acc_load_val,
    input  wire logic                  flags_load,
    input  wire dade_pkg::dade_flags_s flags_load_val,
    input  wire logic [7:0]            mem_rdata,
    output var  logic [3:0]            q_phase,
    output var  logic                  instr_taken,
    output var  logic                  unsupported,
    output var  logic [11:0]           mem_addr,
    output var  logic                  mem_re,
    output var  logic                  mem_we,
    output var  logic [7:0]            mem_wdata,
    output var  logic [7:0]            acc,
    output var  dade_pkg::dade_flags_s flags,
    output var  logic                  done
);

    dade_pkg::dade_phase_e             phase_reg,  phase_next;
    dade_pkg::dade_op_e                op_reg,     op_next;
    logic [dade_pkg::FIELD_W-1:0]      ins_reg,    ins_next;
    logic                              taken_reg,  taken_next;
    logic                              unsup_reg,  unsup_next;
    logic [11:0]                       addr_reg,   addr_next;
    logic                              re_reg,     re_next;
    logic                              we_reg,     we_next;
    logic [7:0]                        wdata_reg,  wdata_next;
    logic [7:0]                        res_reg,    res_next;
    dade_pkg::dade_flags_s             rflags_reg, rflags_next;
    logic [7:0]                        acc_reg,    acc_next;
    dade_pkg::dade_flags_s             flags_reg,  flags_next;
    logic                              done_reg,   done_next;

    logic [7:0]            fsel;
    logic [11:0]           eff_addr;
    logic                  lo_fix, hi_fix;
    logic [4:0]            lo_sum, hi_in, hi_sum;
    logic [7:0]            adj_res, dec_res;
    dade_pkg::dade_flags_s adj_flags, dec_flags;

    // operand address: banked, indexed literal offset, or split access bank
    always_comb begin
        fsel = ins_reg[7:0];
        if (ins_reg[dade_pkg::BANK_BIT]) begin
            eff_addr = {bank_pointer_reg, fsel};
        end else if (ext_set_en && fsel <= dade_pkg::ILO_LIMIT) begin
            eff_addr = 12'(index_base + {4'h0, fsel});
        end else if (fsel >= dade_pkg::ACC_SPLIT) begin
            eff_addr = {dade_pkg::ACC_HI_PAGE, fsel};
        end else begin
            eff_addr = {dade_pkg::ACC_LO_PAGE, fsel};
        end
    end

    // decimal adjust; the carry out of the low correction feeds the high nibble
    always_comb begin
        lo_fix  = ({1'b0, acc_reg[3:0]} > dade_pkg::NIB_MAX) || flags_reg.half_carry_flag;
        lo_sum  = {1'b0, acc_reg[3:0]} + (lo_fix ? dade_pkg::BCD_FIX : 5'h00);
        hi_in   = {1'b0, acc_reg[7:4]} + {4'h0, lo_sum[4]};
        hi_fix  = (hi_in > dade_pkg::NIB_MAX) || flags_reg.c;
        hi_sum  = hi_in + (hi_fix ? dade_pkg::BCD_FIX : 5'h00);
        adj_res = {hi_sum[3:0], lo_sum[3:0]};
        adj_flags   = flags_reg;
        adj_flags.c = flags_reg.c | hi_sum[4];
    end

    // decrement: carry and half-carry mean no borrow
    always_comb begin
        dec_res      = mem_rdata - dade_pkg::ONE;
        dec_flags.c  = (mem_rdata != 8'h00);
        dec_flags.half_carry_flag  = (mem_rdata[3:0] != 4'h0);
        dec_flags.n  = dec_res[7];
        dec_flags.signed_wrap_flag = (mem_rdata == dade_pkg::SIGN_MIN);
        dec_flags.z  = (dec_res == 8'h00);
    end

    always_comb begin
        phase_next  = phase_reg;
        op_next     = op_reg;
        ins_next    = ins_reg;
        taken_next  = 1'b0;
        unsup_next  = 1'b0;
        addr_next   = addr_reg;
        re_next     = 1'b0;
        we_next     = 1'b0;
        wdata_next  = wdata_reg;
        res_next    = res_reg;
        rflags_next = rflags_reg;
        acc_next    = acc_load ? acc_load_val : acc_reg;
        flags_next  = flags_load ? flags_load_val : flags_reg;
        done_next   = 1'b0;
        unique case (phase_reg)
            dade_pkg::DADE_Q1: begin
                phase_next = dade_pkg::DADE_Q2;
                op_next    = dade_pkg::DADE_OP_NONE;
                if (instr_valid) begin
                    taken_next = 1'b1;
                    ins_next   = instr[dade_pkg::FIELD_W-1:0];
                    if (instr == dade_pkg::DECADJ_OPCODE) begin
                        op_next = dade_pkg::DADE_OP_ADJ;
                    end else if (instr[dade_pkg::PREFIX_MSB:dade_pkg::PREFIX_LSB]
                                 == dade_pkg::DEC_FILE_PREFIX) begin
                        op_next = dade_pkg::DADE_OP_DEC;
                    end else begin
                        unsup_next = 1'b1;
                    end
                end
            end
            dade_pkg::DADE_Q2: begin
                phase_next = dade_pkg::DADE_Q3;
                if (op_reg == dade_pkg::DADE_OP_DEC) begin
                    addr_next = eff_addr;
                    re_next   = 1'b1;
                end
            end
            dade_pkg::DADE_Q3: begin
                phase_next = dade_pkg::DADE_Q4;
                if (op_reg == dade_pkg::DADE_OP_ADJ) begin
                    res_next    = adj_res;
                    rflags_next = adj_flags;
                end else if (op_reg == dade_pkg::DADE_OP_DEC) begin
                    res_next    = dec_res;
                    rflags_next = dec_flags;
                end
            end
            dade_pkg::DADE_Q4: begin
                phase_next = dade_pkg::DADE_Q1;
                // the commit wins over a load arriving in the same cycle
                if (op_reg == dade_pkg::DADE_OP_ADJ) begin
                    acc_next   = res_reg;
                    flags_next = rflags_reg;
                    done_next  = 1'b1;
                end else if (op_reg == dade_pkg::DADE_OP_DEC) begin
                    flags_next = rflags_reg;
                    done_next  = 1'b1;
                    if (!ins_reg[dade_pkg::DEST_BIT]) begin
                        acc_next = res_reg;
                    end else begin
                        we_next    = 1'b1;
                        wdata_next = res_reg;
                    end
                end
            end
            default: begin
                phase_next = dade_pkg::DADE_Q1;
                op_next    = dade_pkg::DADE_OP_NONE;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            phase_reg  <= dade_pkg::DADE_Q1;
            op_reg     <= dade_pkg::DADE_OP_NONE;
            ins_reg    <= '0;
            taken_reg  <= 1'b0;
            unsup_reg  <= 1'b0;
            addr_reg   <= '0;
            re_reg     <= 1'b0;
            we_reg     <= 1'b0;
            wdata_reg  <= '0;
            res_reg    <= '0;
            rflags_reg <= dade_pkg::FLAGS_RST;
            acc_reg    <= dade_pkg::ACC_RST;
            flags_reg  <= dade_pkg::FLAGS_RST;
            done_reg   <= 1'b0;
        end else begin
            phase_reg  <= phase_next;
            op_reg     <= op_next;
            ins_reg    <= ins_next;
            taken_reg  <= taken_next;
            unsup_reg  <= unsup_next;
            addr_reg   <= addr_next;
            re_reg     <= re_next;
            we_reg     <= we_next;
            wdata_reg  <= wdata_next;
            res_reg    <= res_next;
            rflags_reg <= rflags_next;
            acc_reg    <= acc_next;
            flags_reg  <= flags_next;
            done_reg   <= done_next;
        end
    end

    assign q_phase     = phase_reg;
    assign instr_taken = taken_reg;
    assign unsupported = unsup_reg;
    assign mem_addr    = addr_reg;
    assign mem_re      = re_reg;
    assign mem_we      = we_reg;
    assign mem_wdata   = wdata_reg;
    assign acc         = acc_reg;
    assign flags       = flags_reg;
    assign done        = done_reg;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    logic q1, q2, q3, q4, is_adj, is_dec;
    assign q1     = (phase_reg == dade_pkg::DADE_Q1);
    assign q2     = (phase_reg == dade_pkg::DADE_Q2);
    assign q3     = (phase_reg == dade_pkg::DADE_Q3);
    assign q4     = (phase_reg == dade_pkg::DADE_Q4);
    assign is_adj = (op_reg == dade_pkg::DADE_OP_ADJ);
    assign is_dec = (op_reg == dade_pkg::DADE_OP_DEC);

    property p_phase_walk;
        q1 |=> q2 ##1 q3 ##1 q4 ##1 q1;
    endproperty
    a_phase_walk: assert property (p_phase_walk) else $error("phase sequence broken");

    property p_adj_low_fix;
        (q3 && is_adj && (acc_reg[3:0] > 4'h9 || flags_reg.half_carry_flag))
            |=> res_reg[3:0] == 4'($past(acc_reg[3:0]) + 4'h6);
    endproperty
    a_adj_low_fix: assert property (p_adj_low_fix) else $error("low nibble not corrected");

    property p_adj_low_keep;
        (q3 && is_adj && acc_reg[3:0] <= 4'h9 && !flags_reg.half_carry_flag)
            |=> res_reg[3:0] == $past(acc_reg[3:0]);
    endproperty
    a_adj_low_keep: assert property (p_adj_low_keep) else $error("low nibble changed");

    property p_adj_high;
        (q3 && is_adj && acc_reg[3:0] <= 4'h9 && !flags_reg.half_carry_flag)
            |=> res_reg[7:4] == (($past(acc_reg[7:4]) > 4'h9 || $past(flags_reg.c))
                                 ? 4'($past(acc_reg[7:4]) + 4'h6) : $past(acc_reg[7:4]));
    endproperty
    a_adj_high: assert property (p_adj_high) else $error("high nibble wrong");

    property p_adj_flags;
        (q3 && is_adj) ##1 (q4 && !flags_load) |=>
            flags.half_carry_flag == $past(flags_reg.half_carry_flag, 2)
            && flags.z == $past(flags_reg.z, 2) && flags.n == $past(flags_reg.n, 2)
            && flags.signed_wrap_flag == $past(flags_reg.signed_wrap_flag, 2)
            && (flags.c || !$past(flags_reg.c, 2)) && acc == $past(res_reg);
    endproperty
    a_adj_flags: assert property (p_adj_flags) else $error("adjust disturbed flags");

    property p_dec_result;
        (q3 && is_dec) |=> res_reg == 8'($past(mem_rdata) - 8'h01)
            && rflags_reg.z == (res_reg == 8'h00) && rflags_reg.n == res_reg[7]
            && rflags_reg.c == ($past(mem_rdata) != 8'h00)
            && rflags_reg.signed_wrap_flag == ($past(mem_rdata) == 8'h80);
    endproperty
    a_dec_result: assert property (p_dec_result) else $error("decrement result wrong");

    property p_dec_decode;
        (q1 && instr_valid && instr[15:10] == 6'h01) |=> is_dec ##3 done;
    endproperty
    a_dec_decode: assert property (p_dec_decode) else $error("decrement not decoded");

    property p_dest_acc;
        (q4 && is_dec && !ins_reg[9]) |=> acc == $past(res_reg) && !mem_we;
    endproperty
    a_dest_acc: assert property (p_dest_acc) else $error("accumulator not written");

    property p_dest_file;
        (q4 && is_dec && ins_reg[9]) |=> mem_we && mem_wdata == $past(res_reg)
            && mem_addr == $past(mem_addr);
    endproperty
    a_dest_file: assert property (p_dest_file) else $error("file write-back missing");

    property p_bank_addr;
        (q2 && is_dec && ins_reg[8]) |=> mem_re
            && mem_addr == {$past(bank_pointer_reg), $past(ins_reg[7:0])};
    endproperty
    a_bank_addr: assert property (p_bank_addr) else $error("banked address wrong");

    property p_indexed_addr;
        (q2 && is_dec && !ins_reg[8] && ext_set_en && ins_reg[7:0] <= 8'h5F)
            |=> mem_addr == 12'($past(index_base) + {4'h0, $past(ins_reg[7:0])});
    endproperty
    a_indexed_addr: assert property (p_indexed_addr) else $error("indexed address wrong");

    c_adj_done: cover property (q4 && is_adj ##1 done);
    c_dec_to_acc: cover property (q4 && is_dec && !ins_reg[9] ##1 done);
    c_dec_to_file: cover property (mem_we && done);
    c_indexed: cover property (q2 && is_dec && !ins_reg[8] && ext_set_en
                               && ins_reg[7:0] <= 8'h5F);

endmodule : dade_exec

`default_nettype wire

// *** core/dade_pkg.sv ***
// constants, types and phase codes for the decimal adjust / decrement datapath
// assumes one 50 MHz core clock; the four-phase cycle is generated inside the datapath
//
// Behaviour
// - decimal adjust adds 6 to low nibble when above 9 or half-carry set
// - decimal adjust adds low carry to high nibble, then 6 when that sum is above 9 or carry set
// - decrement subtracts one from operand, updates carry, half-carry, negative, wrap, zero
// - decrement recognised by its six-bit prefix, then destination, bank bit, file address
// - destination 0 writes accumulator, destination 1 writes back to the file register
// - bank bit 0 uses access bank, bank bit 1 uses bank pointer register
// - bank bit 0 with extended set, addresses up to 5Fh index from base pointer
package dade_pkg;

    localparam logic [15:0] DECADJ_OPCODE   = 16'h0007;
    localparam logic [5:0]  DEC_FILE_PREFIX = 6'h01;
    localparam int          PREFIX_MSB      = 15;
    localparam int          PREFIX_LSB      = 10;
    localparam int          DEST_BIT        = 9;
    localparam int          BANK_BIT        = 8;
    localparam int          FIELD_W         = 10;
    localparam logic [4:0]  NIB_MAX         = 5'h09;
    localparam logic [4:0]  BCD_FIX         = 5'h06;
    localparam logic [7:0]  ILO_LIMIT       = 8'h5F;
    localparam logic [7:0]  ACC_SPLIT       = 8'h80;
    localparam logic [3:0]  ACC_HI_PAGE     = 4'hF;
    localparam logic [3:0]  ACC_LO_PAGE     = 4'h0;
    localparam logic [7:0]  ACC_RST         = 8'h00;
    localparam logic [7:0]  SIGN_MIN        = 8'h80;
    localparam logic [7:0]  ONE             = 8'h01;

    typedef enum logic [3:0] {
        DADE_Q1 = 4'b0001,
        DADE_Q2 = 4'b0010,
        DADE_Q3 = 4'b0100,
        DADE_Q4 = 4'b1000
    } dade_phase_e;

    typedef enum logic [2:0] {
        DADE_OP_NONE = 3'b001,
        DADE_OP_ADJ  = 3'b010,
        DADE_OP_DEC  = 3'b100
    } dade_op_e;

    typedef struct packed {
        logic n;
        logic signed_wrap_flag;
        logic z;
        logic half_carry_flag;
        logic c;
    } dade_flags_s;

    localparam dade_flags_s FLAGS_RST = '{default: 1'b0};

endpackage : dade_pkg

// *** dv/decimal_adjust_decrement_exec_test.sv ***
// self-checking bench for the decimal adjust / decrement datapath
// assumes core/dade_pkg.sv and core/dade_exec.sv are compiled first; the bench plays data memory
`timescale 1ns/1ps
`default_nettype none

module decimal_adjust_decrement_exec_test;
    logic                  clk;
    logic                  rstn;
    logic                  instr_valid;
    logic [15:0]           instr;
    logic                  ext_set_en;
    logic [11:0]           index_base;
    logic [3:0]            bank_pointer_reg;
    logic                  acc_load;
    logic [7:0]            acc_load_val;
    logic                  flags_load;
    dade_pkg::dade_flags_s flags_load_val;
    logic [7:0]            mem_rdata;
    logic [3:0]            q_phase;
    logic                  instr_taken;
    logic                  unsupported;
    logic [11:0]           mem_addr;
    logic                  mem_re;
    logic                  mem_we;
    logic [7:0]            mem_wdata;
    logic [7:0]            acc;
    dade_pkg::dade_flags_s flags;
    logic                  done;
    int                    n_mismatch = 0;
    int                    check_count = 0;
    int                    cycles = 0;

    dade_exec u_dade_exec (.clk(clk), .rstn(rstn), .instr_valid(instr_valid), .instr(instr),
        .ext_set_en(ext_set_en), .index_base(index_base), .bank_pointer_reg(bank_pointer_reg),
        .acc_load(acc_load), .acc_load_val(acc_load_val), .flags_load(flags_load),
        .flags_load_val(flags_load_val), .mem_rdata(mem_rdata), .q_phase(q_phase),
        .instr_taken(instr_taken), .unsupported(unsupported), .mem_addr(mem_addr),
        .mem_re(mem_re), .mem_we(mem_we), .mem_wdata(mem_wdata), .acc(acc), .flags(flags),
        .done(done));

    initial clk = 1'b0;
    always #10 clk = ~clk;

    task automatic report_and_stop;
        if (n_mismatch == 0 && check_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : report_and_stop

    // a whole run of these frames takes well under a hundred frames
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            n_mismatch++;
            report_and_stop();
        end
    end

    task automatic chk_bit(input string what, input logic exp, input logic got);
        check_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("FAIL %s expected %b seen %b", what, exp, got);
        end
    endtask : chk_bit

    task automatic chk_val(input string what, input logic [11:0] exp, input logic [11:0] got);
        check_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("FAIL %s expected %h seen %h", what, exp, got);
        end
    endtask : chk_val

    task automatic chk_flags(input dade_pkg::dade_flags_s exp, input dade_pkg::dade_flags_s got);
        check_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("FAIL flags expected %b seen %b", exp, got);
        end
    endtask : chk_flags

    task automatic set_mode(input logic ext, input logic [11:0] base, input logic [3:0] bank);
        @(posedge clk);
        ext_set_en       <= ext;
        index_base       <= base;
        bank_pointer_reg <= bank;
    endtask : set_mode

    // one instruction frame: preload acc/flags in Q1, answer the Q3 read, judge the Q1 after
    task automatic run(input logic [15:0] w, input logic [7:0] rd, input logic [7:0] acc0,
                       input dade_pkg::dade_flags_s fl0, input logic uns, input logic re,
                       input logic [11:0] addr, input logic we, input logic [7:0] wd,
                       input logic [7:0] exp_acc, input dade_pkg::dade_flags_s exp_fl);
        @(negedge clk);
        while (q_phase !== 4'h8) @(negedge clk);
        @(posedge clk);
        instr_valid    <= 1'b1;
        instr          <= w;
        acc_load       <= 1'b1;
        acc_load_val   <= acc0;
        flags_load     <= 1'b1;
        flags_load_val <= fl0;
        @(posedge clk);
        instr_valid <= 1'b0;
        acc_load    <= 1'b0;
        flags_load  <= 1'b0;
        @(negedge clk);
        chk_bit("instr_taken", 1'b1, instr_taken);
        chk_bit("unsupported", uns, unsupported);
        @(posedge clk);
        mem_rdata <= rd;
        @(negedge clk);
        chk_bit("mem_re", re, mem_re);
        if (re) chk_val("mem_addr", addr, mem_addr);
        // read data is only valid in the read cycle; show garbage otherwise
        @(posedge clk);
        mem_rdata <= ~rd;
        @(posedge clk);
        @(negedge clk);
        chk_bit("done", ~uns, done);
        chk_bit("mem_we", we, mem_we);
        if (we) chk_val("mem_wdata", {4'h0, wd}, {4'h0, mem_wdata});
        if (we) chk_val("mem_addr", addr, mem_addr);
        chk_val("acc", {4'h0, exp_acc}, {4'h0, acc});
        chk_flags(exp_fl, flags);
    endtask : run

    task automatic t_adjust;
        set_mode(1'b0, 12'h000, 4'h0);
        run(16'h0007, 8'h00, 8'hA5, 5'h00, 0, 0, 12'h000, 0, 8'h00, 8'h05, 5'h01);
        run(16'h0007, 8'h00, 8'hCE, 5'h00, 0, 0, 12'h000, 0, 8'h00, 8'h34, 5'h01);
        run(16'h0007, 8'h00, 8'h9A, 5'h00, 0, 0, 12'h000, 0, 8'h00, 8'h00, 5'h01);
        run(16'h0007, 8'h00, 8'h11, 5'h1E, 0, 0, 12'h000, 0, 8'h00, 8'h17, 5'h1E);
        run(16'h0007, 8'h00, 8'h12, 5'h01, 0, 0, 12'h000, 0, 8'h00, 8'h72, 5'h01);
    endtask : t_adjust

    task automatic t_dec_bank;
        set_mode(1'b1, 12'hFF0, 4'h3);
        run(16'h0745, 8'h01, 8'h5A, 5'h00, 0, 1, 12'h345, 1, 8'h00, 8'h5A, 5'h07);
    endtask : t_dec_bank

    task automatic t_dec_access;
        set_mode(1'b0, 12'hFF0, 4'h3);
        run(16'h0490, 8'h00, 8'h5A, 5'h0F, 0, 1, 12'hF90, 0, 8'h00, 8'hFF, 5'h10);
        run(16'h047F, 8'h80, 8'h5A, 5'h00, 0, 1, 12'h07F, 0, 8'h00, 8'h7F, 5'h09);
    endtask : t_dec_access

    task automatic t_dec_indexed;
        set_mode(1'b1, 12'hFF0, 4'h3);
        run(16'h065F, 8'h10, 8'h5A, 5'h00, 0, 1, 12'h04F, 1, 8'h0F, 8'h5A, 5'h01);
        run(16'h0460, 8'hF0, 8'h5A, 5'h00, 0, 1, 12'h060, 0, 8'h00, 8'hEF, 5'h11);
    endtask : t_dec_indexed

    task automatic t_unsupported;
        set_mode(1'b0, 12'h000, 4'h1);
        run(16'h0845, 8'h01, 8'h3C, 5'h15, 1, 0, 12'h000, 0, 8'h00, 8'h3C, 5'h15);
        run(16'h0006, 8'h01, 8'h3C, 5'h0A, 1, 0, 12'h000, 0, 8'h00, 8'h3C, 5'h0A);
        run(16'h0645, 8'h01, 8'h3C, 5'h00, 0, 1, 12'h045, 1, 8'h00, 8'h3C, 5'h07);
    endtask : t_unsupported

    initial begin
        rstn             = 1'b0;
        instr_valid      = 1'b0;
        instr            = 16'h0000;
        ext_set_en       = 1'b0;
        index_base       = 12'h000;
        bank_pointer_reg = 4'h0;
        acc_load         = 1'b0;
        acc_load_val     = 8'h00;
        flags_load       = 1'b0;
        flags_load_val   = 5'h00;
        mem_rdata        = 8'hA5;
        repeat (3) @(posedge clk);
        chk_val("q_phase", 12'h001, {8'h00, q_phase});
        chk_val("acc", 12'h000, {4'h0, acc});
        chk_flags(5'h00, flags);
        rstn <= 1'b1;
        t_adjust();
        t_dec_bank();
        t_dec_access();
        t_dec_indexed();
        t_unsupported();
        report_and_stop();
    end
endmodule : decimal_adjust_decrement_exec_test

`default_nettype wire
